/* File: logic/lane_ctrl_pkg.sv */
// package of constants for the serial flash lane control block
package lane_ctrl_pkg;
    // register indices on the plain register port
    localparam logic [3:0] ADDR_CFG = 4'h0;
    localparam logic [3:0] ADDR_STATUS = 4'h1;
    localparam logic [3:0] ADDR_TX = 4'h2;
    localparam logic [3:0] ADDR_RX = 4'h3;
    localparam logic [3:0] ADDR_STATE = 4'h4;
    // configuration and status fields
    localparam int CFG_PAUSE_OFF_BIT = 4;
    localparam int CFG_PROTO_LSB = 0;
    localparam int CFG_DTR_BIT = 2;
    localparam int CFG_SHARED_BIT = 3;
    localparam int CFG_WIDTH_LSB = 5;
    localparam int STATUS_WDIS_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    // protocol encodings
    localparam logic [1:0] PROTO_EXT = 2'h0;
    localparam logic [1:0] PROTO_DUAL = 2'h1;
    localparam logic [1:0] PROTO_QUAD = 2'h2;
    // lane width of the current command in extended protocol
    localparam logic [1:0] WIDTH_X1 = 2'h0;
    localparam logic [1:0] WIDTH_X2 = 2'h1;
    localparam logic [1:0] WIDTH_X4 = 2'h2;
    localparam logic [7:0] CMD_WRITE_STATUS = 8'h01;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
endpackage

/* File: logic/pin_sync.sv */
// three flop synchroniser with agreement filter for one pin
`timescale 1ns/100ps
`default_nettype none
module pin_sync (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // pin and filtered level
    input wire logic pin_in,
    input wire logic rst_val_in,
    output logic level_out
);
    logic s1_r;
    logic s2_r;
    logic s3_r;

    // first flop feeds only the second; change counts when 2 and 3 agree
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            // reset to the pin's idle level, so no false edge follows reset
            s1_r <= rst_val_in;
            s2_r <= rst_val_in;
            s3_r <= rst_val_in;
            level_out <= rst_val_in;
        end else if (ce_in) begin
            s1_r <= pin_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_out <= s3_r;
            end
        end
    end
endmodule
`default_nettype wire

/* File: logic/serial_flash_pin_lane_control.sv */
// device side lane control: pause, write protect and lane steering
`timescale 1ns/100ps
`default_nettype none
module serial_flash_pin_lane_control (
    // clock, reset, enable
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // register port
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    // link pins from the host
    input wire logic select_n_in,
    input wire logic sclk_in,
    input wire logic pause_n_in,
    input wire logic [3:0] lane_in,
    // lane drive, enables low while driving
    output logic [3:0] lane_out,
    output logic [3:0] lane_oe_n_out,
    // status
    output logic protect_block_out,
    output logic busy_out
);
    logic sel_n;
    logic sclk;
    logic pause_n;
    logic [3:0] lane_s;
    logic sclk_d_r;
    logic [7:0] cfg_r;
    logic [7:0] status_r;
    logic [7:0] tx_r;
    logic [7:0] rx_r;
    logic [7:0] shift_r;
    logic [3:0] bitcnt_r;
    logic first_r;
    logic [7:0] cmd_r;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, idle values chosen to look deselected
    pin_sync u_sel (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .pin_in(select_n_in), .rst_val_in(1'b1), .level_out(sel_n));
    pin_sync u_clk (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .pin_in(sclk_in), .rst_val_in(1'b0), .level_out(sclk));
    pin_sync u_pause (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .pin_in(pause_n_in), .rst_val_in(1'b1), .level_out(pause_n));
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_lane
            pin_sync u_lane (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
                .pin_in(lane_in[g]), .rst_val_in(1'b0), .level_out(lane_s[g]));
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // mode decode
    logic [1:0] proto;
    logic [1:0] width;
    logic dtr;
    logic quad;
    logic dual;
    logic pause_on;
    logic paused;
    logic active;
    logic rise;
    logic fall;
    logic sel_fall;
    logic [3:0] step;
    logic wp_n;
    logic sel_n_d_r;
    assign proto = cfg_r[lane_ctrl_pkg::CFG_PROTO_LSB +: 2];
    assign width = cfg_r[lane_ctrl_pkg::CFG_WIDTH_LSB +: 2];
    assign dtr = cfg_r[lane_ctrl_pkg::CFG_DTR_BIT];
    assign quad = (proto == lane_ctrl_pkg::PROTO_QUAD) || (proto == lane_ctrl_pkg::PROTO_EXT
        && width == lane_ctrl_pkg::WIDTH_X4);
    assign dual = (proto == lane_ctrl_pkg::PROTO_DUAL) || (proto == lane_ctrl_pkg::PROTO_EXT
        && width == lane_ctrl_pkg::WIDTH_X2);
    // pause off by bit 4, or forced off on shared pin in quad/dtr
    assign pause_on = !cfg_r[lane_ctrl_pkg::CFG_PAUSE_OFF_BIT]
        && !(cfg_r[lane_ctrl_pkg::CFG_SHARED_BIT]
        && (proto == lane_ctrl_pkg::PROTO_QUAD || dtr));
    assign paused = pause_on && !pause_n;
    assign active = !sel_n && !paused;
    assign rise = sclk && !sclk_d_r;
    assign fall = !sclk && sclk_d_r;
    assign sel_fall = !sel_n && sel_n_d_r;
    assign step = quad ? 4'h4 : (dual ? 4'h2 : 4'h1);
    // protect pin is lane two; only a protect input outside quad
    assign wp_n = lane_s[2];

    // edge history; clock history held while paused so no edge is lost or invented, select history always tracks
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            sclk_d_r <= 1'b0;
            sel_n_d_r <= 1'b1;
        end else if (ce_in) begin
            sel_n_d_r <= sel_n;
            if (!paused) begin
                sclk_d_r <= sclk;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // shifter: input on rising edges, or both edges in dtr after the command byte
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            shift_r <= 8'h00;
            bitcnt_r <= 4'h0;
            first_r <= 1'b1;
            cmd_r <= 8'h00;
            rx_r <= 8'h00;
        end else if (ce_in) begin
            if (sel_n) begin
                bitcnt_r <= 4'h0;
                first_r <= 1'b1;
                cmd_r <= 8'h00; // a stale command must not fire again at a later deselect
            end else if (active && (rise || (dtr && fall && !first_r))) begin
                if (quad) begin
                    shift_r <= {shift_r[3:0], lane_s};
                end else if (dual) begin
                    shift_r <= {shift_r[5:0], lane_s[1:0]};
                end else begin
                    shift_r <= {shift_r[6:0], lane_s[0]};
                end
                if (bitcnt_r + step >= lane_ctrl_pkg::BITS_PER_BYTE) begin
                    bitcnt_r <= 4'h0;
                    first_r <= 1'b0;
                    if (first_r) begin
                        cmd_r <= quad ? {shift_r[3:0], lane_s}
                            : (dual ? {shift_r[5:0], lane_s[1:0]} : {shift_r[6:0], lane_s[0]});
                    end else begin
                        rx_r <= quad ? {shift_r[3:0], lane_s}
                            : (dual ? {shift_r[5:0], lane_s[1:0]} : {shift_r[6:0], lane_s[0]});
                    end
                end else begin
                    bitcnt_r <= bitcnt_r + step;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output drive: launch on falling edge, or both edges in dtr; tri-state when deselected, paused or in the command byte
    logic [7:0] out_sh_r;
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            out_sh_r <= 8'h00;
            lane_out <= 4'h0;
            lane_oe_n_out <= 4'hF;
        end else if (ce_in) begin
            if (!active || first_r) begin
                lane_oe_n_out <= 4'hF;
                if (sel_fall) begin
                    out_sh_r <= tx_r;
                end
            end else if (fall || (dtr && rise)) begin
                if (quad) begin
                    lane_out <= out_sh_r[7:4];
                    lane_oe_n_out <= 4'h0;
                    out_sh_r <= {out_sh_r[3:0], out_sh_r[7:4]};
                end else if (dual) begin
                    lane_out <= {2'b00, out_sh_r[7:6]};
                    lane_oe_n_out <= 4'hC;
                    out_sh_r <= {out_sh_r[5:0], out_sh_r[7:6]};
                end else begin
                    lane_out <= {2'b00, out_sh_r[7], 1'b0};
                    lane_oe_n_out <= 4'hD;
                    out_sh_r <= {out_sh_r[6:0], out_sh_r[7]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status write at deselect, refused under hardware protect
    logic protect;
    assign protect = status_r[lane_ctrl_pkg::STATUS_WDIS_BIT] && !wp_n && !quad;
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            status_r <= lane_ctrl_pkg::STATUS_RESET;
            protect_block_out <= 1'b0;
            busy_out <= 1'b0;
        end else if (ce_in) begin
            protect_block_out <= protect;
            busy_out <= !sel_n && !first_r;
            if (wr_in && addr_in == lane_ctrl_pkg::ADDR_STATUS && !protect) begin
                status_r <= wdata_in;
            end else if (sel_n && !sel_n_d_r && cmd_r == lane_ctrl_pkg::CMD_WRITE_STATUS
                && !protect) begin
                status_r <= rx_r;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register port: config and transmit byte, one-cycle read data
    always_ff @(posedge clock_in) begin
        if (!nrst_in) begin
            cfg_r <= lane_ctrl_pkg::CFG_RESET;
            tx_r <= 8'h00;
            rdata_out <= 8'h00;
        end else if (ce_in) begin
            if (wr_in && addr_in == lane_ctrl_pkg::ADDR_CFG) begin
                cfg_r <= wdata_in;
            end
            if (wr_in && addr_in == lane_ctrl_pkg::ADDR_TX) begin
                tx_r <= wdata_in;
            end
            rdata_out <= 8'h00;
            if (rd_in) begin
                unique case (addr_in)
                    lane_ctrl_pkg::ADDR_CFG: rdata_out <= cfg_r;
                    lane_ctrl_pkg::ADDR_STATUS: rdata_out <= status_r;
                    lane_ctrl_pkg::ADDR_TX: rdata_out <= tx_r;
                    lane_ctrl_pkg::ADDR_RX: rdata_out <= rx_r;
                    lane_ctrl_pkg::ADDR_STATE: rdata_out <= {paused, protect, sel_n, 1'b0,
                        bitcnt_r};
                    default: rdata_out <= 8'h00;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/lane_ctrl_props.sv */
// checker for the lane control block, bound to its ports
`timescale 1ns/100ps
`default_nettype none
module lane_ctrl_props (
    // clock and reset
    input wire logic clock_in,
    input wire logic nrst_in,
    input wire logic ce_in,
    // register port
    input wire logic [3:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] rdata_out,
    // link pins
    input wire logic select_n_in,
    input wire logic pause_n_in,
    input wire logic [3:0] lane_in,
    input wire logic [3:0] lane_oe_n_out,
    input wire logic protect_block_out
);
    logic [7:0] cfg_r;
    logic pause_on;
    // shadow of the config register; bench only changes it while deselected
    always_ff @(posedge clock_in) begin
        if (!nrst_in) cfg_r <= lane_ctrl_pkg::CFG_RESET;
        else if (ce_in && wr_in && addr_in == lane_ctrl_pkg::ADDR_CFG) cfg_r <= wdata_in;
    end
    // pause counts unless switched off or lost to the shared lane
    assign pause_on = !cfg_r[4] && !(cfg_r[3] && (cfg_r[1:0] == 2'h2 || cfg_r[2]));
    default clocking @(posedge clock_in); endclocking
    default disable iff (!nrst_in);
    // six cycles cover the pin synchroniser latency
    sequence desel_s; select_n_in [*6]; endsequence
    sequence held_s; (!pause_n_in && pause_on) [*6]; endsequence
    sequence wp_high_s; lane_in[2] [*6]; endsequence
    sequence quad_s; (cfg_r[1:0] == 2'h2) [*6]; endsequence
    AST_STANDBY: assert property (desel_s |-> lane_oe_n_out == 4'hF)
        else $error("lanes driven while deselected");
    AST_PAUSE: assert property (held_s |-> lane_oe_n_out == 4'hF)
        else $error("lanes driven while paused");
    AST_X1: assert property (cfg_r[1:0] == 2'h0 && cfg_r[6:5] == 2'h0 |->
        lane_oe_n_out[0] && lane_oe_n_out[3:2] == 2'h3) else $error("single lane misuse");
    AST_DUAL: assert property ((cfg_r[1:0] == 2'h1 || cfg_r[6:5] == 2'h1 &&
        cfg_r[1:0] == 2'h0) |-> lane_oe_n_out[3:2] == 2'h3) else $error("upper lanes driven");
    AST_WP_FREE: assert property (wp_high_s |-> !protect_block_out)
        else $error("protect without low pin");
    AST_QUAD_WP: assert property (quad_s |-> !protect_block_out)
        else $error("protect pin honoured in quad");
    AST_CFG_READ: assert property (rd_in && addr_in == lane_ctrl_pkg::ADDR_CFG |=>
        rdata_out == $past(cfg_r)) else $error("config read back wrong");
    AST_IDLE_READ: assert property (!rd_in |=> rdata_out == 8'h00)
        else $error("read data outside its cycle");
endmodule
bind serial_flash_pin_lane_control lane_ctrl_props i_props (.clock_in(clock_in),
    .nrst_in(nrst_in), .ce_in(ce_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in),
    .rd_in(rd_in),
    .rdata_out(rdata_out), .select_n_in(select_n_in), .pause_n_in(pause_n_in),
    .lane_in(lane_in), .lane_oe_n_out(lane_oe_n_out), .protect_block_out(protect_block_out));
`default_nettype wire

/* File: tb/host_model.sv */
// behavioural host controller driving select, clock, pause and lanes
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // link pins
    output logic select_n_out,
    output logic sclk_out,
    output logic pause_n_out,
    output logic [3:0] lanes_out,
    input wire logic [3:0] lanes_in
);
    logic d0_r = 1'b0;
    logic tog_r = 1'b0;
    logic wp_r = 1'b1;
    int w_r = 1;
    logic [3:0] wide_r = 4'h0;
    initial begin
        select_n_out = 1'b1;
        sclk_out = 1'b0;
        pause_n_out = 1'b1;
    end
    // protect pin driven from wp_r except at width four; single lane: lane three high, idle lane one keeps moving
    assign lanes_out = (w_r == 4) ? wide_r
        : ((w_r == 2) ? {1'b1, wp_r, wide_r[1:0]} : {1'b1, wp_r, tog_r, d0_r});
    // one frame of 16/w clocks, msb first on w lanes; clock still outside it and in pause
    task automatic frame(input logic [15:0] bits, input int pause_at, input int w,
        output logic [7:0] got);
        logic [15:0] rest;
        logic [3:0] chunk;
        rest = bits;
        got = 8'h00;
        w_r = w;
        #13 select_n_out = 1'b0;
        #400;
        for (int i = 16 / w - 1; i >= 0; i--) begin
            if (i == pause_at) begin
                pause_n_out = 1'b0;
                #2000 pause_n_out = 1'b1;
                #400;
            end
            chunk = rest[15:12] >> (4 - w);
            rest = rest << w;
            d0_r = chunk[0];
            wide_r = chunk;
            tog_r = ~tog_r;
            #200 sclk_out = 1'b1;
            #199;
            if (i < 8 / w && w == 1) got = {got[6:0], lanes_in[1]};
            if (i < 8 / w && w == 2) got = {got[5:0], lanes_in[1:0]};
            if (i < 8 / w && w == 4) got = {got[3:0], lanes_in};
            #1 sclk_out = 1'b0;
        end
        #400 select_n_out = 1'b1;
        d0_r = ~d0_r;
        #800;
        w_r = 1;
    endtask
endmodule
`default_nettype wire

/* File: tb/serial_flash_pin_lane_control_test.sv */
// testbench for the lane control block with a host model
`timescale 1ns/100ps
`default_nettype none
module serial_flash_pin_lane_control_test;
    logic clock_in = 1'b0;
    logic nrst_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00;
    logic ce_in = 1'b1;
    logic [7:0] exp_oe, exp_state;
    logic [7:0] rdata_out, got;
    logic [3:0] lane_out, lane_oe_n_out, host_lanes, wire_lanes;
    logic select_n, sclk, pause_n, protect_block_out, busy_out;
    int fails = 0;
    int comparisons = 0;
    always #25 clock_in = ~clock_in;
    // wire level: the device wins each lane it enables
    assign wire_lanes = (lane_oe_n_out & host_lanes) | (~lane_oe_n_out & lane_out);
    host_model i_host (.select_n_out(select_n), .sclk_out(sclk), .pause_n_out(pause_n),
        .lanes_out(host_lanes), .lanes_in(wire_lanes));
    serial_flash_pin_lane_control i_dut (.clock_in(clock_in), .nrst_in(nrst_in), .ce_in(ce_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .select_n_in(select_n), .sclk_in(sclk), .pause_n_in(pause_n),
        .lane_in(wire_lanes), .lane_out(lane_out), .lane_oe_n_out(lane_oe_n_out),
        .protect_block_out(protect_block_out), .busy_out(busy_out));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, input logic [7:0] e, input string n);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 chk(n, e, rdata_out);
    endtask
    task automatic final_report;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // watchdog well beyond the few frames of the run
    initial begin
        #2000000 fails++;
        final_report;
    end
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock_in);
        nrst_in <= 1'b1;
        repeat (4) @(posedge clock_in);
        rd(lane_ctrl_pkg::ADDR_CFG, lane_ctrl_pkg::CFG_RESET, "cfg reset");
        rd(lane_ctrl_pkg::ADDR_STATUS, lane_ctrl_pkg::STATUS_RESET, "status reset");
        rd(4'hF, 8'h00, "unmapped");
        // clock enable low: a write in that cycle must leave no trace
        @(posedge clock_in);
        ce_in <= 1'b0;
        wr(lane_ctrl_pkg::ADDR_CFG, 8'h10);
        ce_in <= 1'b1;
        rd(lane_ctrl_pkg::ADDR_CFG, lane_ctrl_pkg::CFG_RESET, "frozen cfg");
        $display("test reset done");
        // pause honoured, switched off by bit 4, forced off on the shared lane in quad
        for (int k = 0; k < 3; k++) begin
            exp_oe = (k == 0) ? 8'h0F : ((k == 1) ? 8'h0D : 8'h00);
            exp_state = (k == 0) ? 8'h83 : ((k == 1) ? 8'h03 : 8'h00);
            wr(lane_ctrl_pkg::ADDR_CFG, (k == 0) ? 8'h00 : ((k == 1) ? 8'h10 : 8'h0A));
            wr(lane_ctrl_pkg::ADDR_TX, 8'hA5);
            fork
                i_host.frame({8'h0B, 8'h3C}, (k == 2) ? 1 : 4, (k == 2) ? 4 : 1, got);
                begin
                    wait (!pause_n);
                    #1500 chk("paused oe", exp_oe, {4'h0, lane_oe_n_out});
                    chk("busy in pause", 8'h01, {7'h0, busy_out});
                    rd(lane_ctrl_pkg::ADDR_STATE, exp_state, "paused state");
                end
            join
            chk("out byte", 8'hA5, got);
            chk("busy idle", 8'h00, {7'h0, busy_out});
            if (k < 2) rd(lane_ctrl_pkg::ADDR_RX, 8'h3C, "rx byte");
        end
        $display("test pause done");
        // two lanes each way under the dual protocol
        wr(lane_ctrl_pkg::ADDR_CFG, 8'h01);
        wr(lane_ctrl_pkg::ADDR_TX, 8'h5A);
        i_host.frame({8'h0B, 8'h3C}, -1, 2, got);
        chk("dual byte", 8'h5A, got);
        $display("test dual done");
        // status freeze by bit 7 and a low protect pin
        wr(lane_ctrl_pkg::ADDR_CFG, 8'h00);
        wr(lane_ctrl_pkg::ADDR_STATUS, 8'h80);
        i_host.wp_r = 1'b0;
        repeat (8) @(posedge clock_in);
        chk("protect", 8'h01, {7'h0, protect_block_out});
        wr(lane_ctrl_pkg::ADDR_STATUS, 8'h00);
        rd(lane_ctrl_pkg::ADDR_STATUS, 8'h80, "status kept");
        i_host.frame({8'h01, 8'h00}, -1, 1, got);
        repeat (20) @(posedge clock_in);
        rd(lane_ctrl_pkg::ADDR_STATUS, 8'h80, "serial write refused");
        wr(lane_ctrl_pkg::ADDR_CFG, 8'h02);
        repeat (8) @(posedge clock_in);
        chk("quad protect", 8'h00, {7'h0, protect_block_out});
        wr(lane_ctrl_pkg::ADDR_CFG, 8'h01);
        wr(lane_ctrl_pkg::ADDR_CFG, 8'h00);
        i_host.wp_r = 1'b1;
        repeat (8) @(posedge clock_in);
        chk("protect off", 8'h00, {7'h0, protect_block_out});
        i_host.frame({8'h01, 8'h00}, -1, 1, got);
        repeat (20) @(posedge clock_in);
        rd(lane_ctrl_pkg::ADDR_STATUS, 8'h00, "serial write taken");
        $display("test protect done");
        final_report;
    end
endmodule
`default_nettype wire
